// File: fof_consts.svh
// constants for the fifo flag and offset programming block
// assumes it is included by fof_pkg.sv and fof_flags_offset.sv
//
// Behaviour
// R1 - master reset loads empty offset 127 (parallel) or 1023 (serial)
// R2 - master reset loads full offset 127 (parallel) or 1023 (serial)
// R3 - standard mode: almost-full low from depth minus full offset up to depth
// R4 - fall-through: almost-empty low from zero to empty offset plus one words
// R5 - fall-through: half-full low from half depth plus two words up to full
// R6 - fall-through: almost-full low from depth plus one minus full offset
// R7 - load, write enable low, others high: write data into offsets, empty first
// R8 - load, read enable low, others high: present offsets on data out, empty first
// R9 - load, serial enable low, enables high: shift one bit per edge, 26 bits
// R10 - loading method captured only during master reset, kept until next
// R11 - parallel readback works whichever loading method was captured
// R12 - offset control decoding identical in standard and fall-through modes
// R13 - serial bits fill empty offset lsb first, end at full offset msb
// R14 - the controller must shift the whole bit set to reprogram offsets
// R15 - load low with serial enable high shifts no serial bit
// R16 - memory writes may interleave serial bits; sequence position is kept
// R17 - serial loading pauses while load or serial enable is high, then resumes
// R18 - partial flags invalid during serial load, valid two edges after last bit
// R19 - offsets read back only over the parallel data outputs; the code also returns them on the bus offset register
// R20 - load high at master reset selects serial with 3FF defaults, low 07F
// R21 - fall-through pin high at master reset selects fall-through timing
// R22 - standard mode: almost-empty high once count exceeds the empty offset
// R23 - load high: write enable low stores data, read enable low reads memory
// R24 - offsets are 13 bits wide, flags compare word count against them
// R25 - separate write and read offset pointers toggle empty to full and back
`ifndef FOF_CONSTS_SVH
`define FOF_CONSTS_SVH

`define FOF_DATA_W      18
`define FOF_OFF_W       13
`define FOF_CNT_W       14
`define FOF_DEPTH       14'h2000
`define FOF_DEPTH_FIRST_WORD_FALLTHROUGH  14'h2001
`define FOF_HALF_STD    14'h1001
`define FOF_HALF_FIRST_WORD_FALLTHROUGH   14'h1002
`define FOF_OFF_PAR     13'h007F
`define FOF_OFF_SER     13'h03FF
`define FOF_SER_LAST    5'h19
`define FOF_SER_SPLIT   5'h0D
`define FOF_SETTLE      2'h1
`define FOF_ADR_CTRL    4'h0
`define FOF_ADR_STATUS  4'h4
`define FOF_ADR_COUNT   4'h8
`define FOF_ADR_OFFS    4'hC

`endif

// File: fof_pkg.sv
// types for the fifo flag and offset programming block
// assumes fof_consts.svh is found on the include path
`include "fof_consts.svh"

package fof_pkg;

    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic half_full_n;
        logic almost_empty_n;
        logic empty_n;
    } fof_flags_t;

    typedef struct packed {
        logic [1:0]                       mrs_s;
        logic [1:0]                       ld_s;
        logic [1:0]                       wen_s;
        logic [1:0]                       ren_s;
        logic [1:0]                       sen_s;
        logic [1:0]                       fsi_s;
        logic [1:0][`FOF_DATA_W-1:0]      din_s;
        logic                             first_word_fallthrough;
        logic                             serial_mode;
        logic [`FOF_OFF_W-1:0]            wr_ptr;
        logic [`FOF_OFF_W-1:0]            rd_ptr;
        logic [`FOF_CNT_W-1:0]            mem_cnt;
        logic                             out_valid;
        logic [`FOF_DATA_W-1:0]           dout;
        logic [1:0][`FOF_OFF_W-1:0]       offs;
        logic                             off_wptr;
        logic                             off_rptr;
        logic [4:0]                       bit_idx;
        logic [1:0]                       settle;
        fof_flags_t                       flags;
        logic                             soft_rst;
        logic                             wb_ack;
        logic [31:0]                      wb_dat;
    } fof_state_t;

endpackage

// File: fof_flags_offset.sv
// fifo memory, status flags and flag offset programming, one clock domain
// assumes pins arrive asynchronously and a classic wishbone master on clock_i
`timescale 1ns/100ps
`default_nettype none
`include "fof_consts.svh"

module fof_flags_offset (
    input  wire logic                    clock_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    master_reset_n_i,
    input  wire logic                    load_select_n_i,
    input  wire logic                    write_enable_n_i,
    input  wire logic                    read_enable_n_i,
    input  wire logic                    serial_enable_n_i,
    input  wire logic                    fallthrough_serial_pin_i,
    input  wire logic [`FOF_DATA_W-1:0]  data_in_bus_i,
    output logic      [`FOF_DATA_W-1:0]  data_out_bus_o,
    output fof_pkg::fof_flags_t          flags_o,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o
);

    // ****************************************
    // reset image and storage
    // ****************************************
    localparam fof_pkg::fof_state_t RESET_STATE = '{
        offs:  {`FOF_OFF_PAR, `FOF_OFF_PAR},
        flags: '{full_n: 1'b1, almost_full_n: 1'b1, half_full_n: 1'b1,
                 almost_empty_n: 1'b0, empty_n: 1'b0},
        default: '0
    };

    fof_pkg::fof_state_t            st_reg;
    fof_pkg::fof_state_t            st_next;
    logic [`FOF_DATA_W-1:0]         mem [0:`FOF_DEPTH-1];
    logic [`FOF_DATA_W-1:0]         mem_rdata;
    logic                           mem_we;
    logic                           mst_rst;
    logic                           ld_n;
    logic                           wen_n;
    logic                           ren_n;
    logic                           sen_n;
    logic                           wr_go;
    logic                           pop;
    logic                           consume;
    logic                           par_wr;
    logic                           par_rd;
    logic                           ser_go;
    logic                           frozen;
    logic [`FOF_CNT_W-1:0]          total;
    logic [`FOF_CNT_W-1:0]          cap;
    logic [`FOF_CNT_W-1:0]          empty_off;
    logic [`FOF_CNT_W-1:0]          full_off;
    logic                           wb_hit;

    assign mem_rdata = mem[st_reg.rd_ptr];
    assign mst_rst   = ~st_reg.mrs_s[1] | st_reg.soft_rst;
    assign ld_n      = st_reg.ld_s[1];
    assign wen_n     = st_reg.wen_s[1];
    assign ren_n     = st_reg.ren_s[1];
    assign sen_n     = st_reg.sen_s[1];
    assign total     = st_reg.mem_cnt + {13'h0000, st_reg.out_valid};
    assign cap       = st_reg.first_word_fallthrough ? `FOF_DEPTH_FIRST_WORD_FALLTHROUGH : `FOF_DEPTH;
    assign empty_off = {1'b0, st_reg.offs[0]};
    assign full_off  = {1'b0, st_reg.offs[1]};
    assign frozen    = (st_reg.bit_idx != 5'h00) || (st_reg.settle != 2'h0);
    assign wb_hit    = wb_cyc_i & wb_stb_i & ~st_reg.wb_ack;

    // ****************************************
    // control decode
    // ****************************************
    always_comb begin
        // write and offset decode do not look at the timing mode, only pop does
        wr_go   = ~mst_rst & ld_n & ~wen_n & (st_reg.mem_cnt != `FOF_DEPTH); // R23 R12
        consume = ld_n & ~ren_n & st_reg.out_valid;
        if (st_reg.first_word_fallthrough) begin
            pop = ~mst_rst & (~st_reg.out_valid | consume) & (st_reg.mem_cnt != 14'h0000);
        end else begin
            pop = ~mst_rst & ld_n & ~ren_n & (st_reg.mem_cnt != 14'h0000); // R23
        end
        par_wr = ~mst_rst & ~ld_n & ~wen_n & ren_n & sen_n & ~st_reg.serial_mode; // R7
        par_rd = ~mst_rst & ~ld_n & wen_n & ~ren_n & sen_n; // R8 R11 R19
        ser_go = ~mst_rst & ~ld_n & wen_n & ren_n & ~sen_n & st_reg.serial_mode; // R9 R15 R17
        mem_we = wr_go;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.mrs_s = {st_reg.mrs_s[0], master_reset_n_i};
        st_next.ld_s  = {st_reg.ld_s[0], load_select_n_i};
        st_next.wen_s = {st_reg.wen_s[0], write_enable_n_i};
        st_next.ren_s = {st_reg.ren_s[0], read_enable_n_i};
        st_next.sen_s = {st_reg.sen_s[0], serial_enable_n_i};
        st_next.fsi_s = {st_reg.fsi_s[0], fallthrough_serial_pin_i};
        st_next.din_s = {st_reg.din_s[0], data_in_bus_i};
        st_next.wb_ack = wb_hit;

        if (mst_rst) begin
            st_next.first_word_fallthrough        = st_reg.fsi_s[1]; // R21 R10
            st_next.serial_mode = ld_n; // R10 R20
            if (ld_n) begin
                st_next.offs = {`FOF_OFF_SER, `FOF_OFF_SER}; // R1 R2 R20
            end else begin
                st_next.offs = {`FOF_OFF_PAR, `FOF_OFF_PAR}; // R1 R2 R20
            end
            st_next.wr_ptr    = '0;
            st_next.rd_ptr    = '0;
            st_next.mem_cnt   = '0;
            st_next.out_valid = 1'b0;
            st_next.off_wptr  = 1'b0;
            st_next.off_rptr  = 1'b0;
            st_next.bit_idx   = '0;
            st_next.settle    = '0;
            st_next.flags     = '{full_n: ~st_reg.fsi_s[1], almost_full_n: 1'b1,
                                  half_full_n: 1'b1, almost_empty_n: 1'b0,
                                  empty_n: st_reg.fsi_s[1]}; // R21
        end else begin
            if (wr_go) begin
                st_next.wr_ptr = st_reg.wr_ptr + 13'h0001;
            end
            if (pop) begin
                st_next.rd_ptr = st_reg.rd_ptr + 13'h0001;
                st_next.dout   = mem_rdata;
            end
            st_next.mem_cnt = st_reg.mem_cnt + {13'h0000, wr_go} - {13'h0000, pop};
            if (st_reg.first_word_fallthrough) begin
                st_next.out_valid = pop | (st_reg.out_valid & ~consume);
            end
            if (par_wr) begin
                st_next.offs[st_reg.off_wptr] = st_reg.din_s[1][`FOF_OFF_W-1:0]; // R7 R24
                st_next.off_wptr = ~st_reg.off_wptr; // R25
            end
            if (par_rd) begin
                st_next.dout = {5'h00, st_reg.offs[st_reg.off_rptr]}; // R8
                st_next.off_rptr = ~st_reg.off_rptr; // R25
            end
            if (ser_go) begin
                // position survives any pause or interleaved memory write
                if (st_reg.bit_idx < `FOF_SER_SPLIT) begin
                    st_next.offs[0][st_reg.bit_idx[3:0]] = st_reg.fsi_s[1]; // R13
                end else begin
                    st_next.offs[1][4'(st_reg.bit_idx - `FOF_SER_SPLIT)] = st_reg.fsi_s[1]; // R13
                end
                if (st_reg.bit_idx == `FOF_SER_LAST) begin
                    st_next.bit_idx = '0; // R9
                    st_next.settle  = `FOF_SETTLE; // R18
                end else begin
                    st_next.bit_idx = st_reg.bit_idx + 5'h01; // R16 R17
                end
            end else if (st_reg.settle != 2'h0) begin
                st_next.settle = st_reg.settle - 2'h1;
            end

            // flags from the current count and offsets
            if (st_reg.first_word_fallthrough) begin
                st_next.flags.full_n      = (total == cap);
                st_next.flags.empty_n     = ~st_reg.out_valid;
                st_next.flags.half_full_n = ~(total >= `FOF_HALF_FIRST_WORD_FALLTHROUGH); // R5
            end else begin
                st_next.flags.full_n      = (total != cap);
                st_next.flags.empty_n     = (total != 14'h0000);
                st_next.flags.half_full_n = ~(total >= `FOF_HALF_STD);
            end
            if (!frozen) begin
                // partial flags held while the offsets are half loaded
                st_next.flags.almost_full_n = ~(total >= cap - full_off); // R3 R6 R24
                if (st_reg.first_word_fallthrough) begin
                    st_next.flags.almost_empty_n = total > empty_off + 14'h0001; // R4
                end else begin
                    st_next.flags.almost_empty_n = total > empty_off; // R22
                end
            end
        end

        // register bus
        if (wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FOF_ADR_CTRL)) begin
            st_next.soft_rst = wb_dat_i[0];
        end
        st_next.wb_dat = '0;
        if (wb_hit & ~wb_we_i) begin
            unique case (wb_adr_i)
                `FOF_ADR_CTRL:   st_next.wb_dat = {31'h0, st_reg.soft_rst};
                `FOF_ADR_STATUS: st_next.wb_dat = {16'h0, frozen, st_reg.bit_idx,
                                                   st_reg.serial_mode, st_reg.first_word_fallthrough,
                                                   3'h0, st_reg.flags};
                `FOF_ADR_COUNT:  st_next.wb_dat = {18'h0, total};
                `FOF_ADR_OFFS:   st_next.wb_dat = {3'h0, st_reg.offs[1],
                                                   3'h0, st_reg.offs[0]};
                default:         st_next.wb_dat = '0;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st_reg <= RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (mem_we) begin
            mem[st_reg.wr_ptr] <= st_reg.din_s[1];
        end
    end

    assign data_out_bus_o = st_reg.dout;
    assign flags_o        = st_reg.flags;
    assign wb_dat_o       = st_reg.wb_dat;
    assign wb_ack_o       = st_reg.wb_ack;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_last_bit;
        ser_go && (st_reg.bit_idx == `FOF_SER_LAST);
    endsequence

    sequence s_settled;
        (st_reg.settle == 2'h1) ##1 (st_reg.settle == 2'h0);
    endsequence

    chk_serial_wrap: assert property (s_last_bit |=> (st_reg.bit_idx == 5'h00) ##0 s_settled) // R9
        else $error("serial load did not wrap and settle");
    chk_flags_frozen: assert property ((frozen && !mst_rst) |=> $stable(st_reg.flags.almost_full_n) && $stable(st_reg.flags.almost_empty_n)) // R18
        else $error("partial flag moved while offsets invalid");
    chk_mode_hold: assert property (!mst_rst && !$past(mst_rst) |=> $stable(st_reg.serial_mode) && $stable(st_reg.first_word_fallthrough)) // R10
        else $error("loading method changed outside master reset");
    chk_serial_default: assert property (mst_rst && ld_n |=> st_reg.offs == {`FOF_OFF_SER, `FOF_OFF_SER}) // R1
        else $error("serial default offsets wrong");
    chk_serial_pause: assert property (!ser_go && !mst_rst |=> $stable(st_reg.bit_idx)) // R17
        else $error("serial position moved while paused");
    chk_par_write: assert property (par_wr |=> st_reg.offs[$past(st_reg.off_wptr)] == $past(st_reg.din_s[1][12:0]) && st_reg.off_wptr != $past(st_reg.off_wptr)) // R7
        else $error("parallel offset write lost");
    chk_par_read: assert property (par_rd |=> st_reg.dout == {5'h00, $past(st_reg.offs[st_reg.off_rptr])}) // R8
        else $error("parallel offset readback wrong");
    chk_af_std: assert property (!st_reg.first_word_fallthrough && !frozen && !mst_rst && total >= `FOF_DEPTH - full_off |=> !st_reg.flags.almost_full_n) // R3
        else $error("almost full not asserted in standard mode");
    chk_ae_first_word_fallthrough: assert property (st_reg.first_word_fallthrough && !frozen && !mst_rst && total <= empty_off + 14'h0001 |=> !st_reg.flags.almost_empty_n) // R4
        else $error("almost empty not low in fall-through mode");
    chk_hf_first_word_fallthrough: assert property (st_reg.first_word_fallthrough && !mst_rst && total >= `FOF_HALF_FIRST_WORD_FALLTHROUGH |=> !st_reg.flags.half_full_n) // R5
        else $error("half full not low in fall-through mode");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");

endmodule
`default_nettype wire

// File: fof_pin_agent.sv
// writer and reader model that drives the fifo control pins
// assumes one caller process and tasks invoked right after a clock_i edge
`timescale 1ns/100ps
`default_nettype none
`include "fof_consts.svh"

module fof_pin_agent (
    input  wire logic                   clock_i,
    output logic                        master_reset_n_o,
    output logic [3:0]                  ctl_o,
    output logic                        serial_o,
    output logic [`FOF_DATA_W-1:0]      data_o
);
    // ctl_o is {load_select_n, write_enable_n, read_enable_n, serial_enable_n}
    initial begin
        master_reset_n_o = 1'b0;
        ctl_o            = 4'hF;
        serial_o         = 1'b0;
        data_o           = 18'h00000;
    end

    // holds one pin state for n edges
    task automatic drive(input logic [3:0] c, input logic s, input logic [17:0] d, input int n);
        @(posedge clock_i);
        ctl_o    <= c;
        serial_o <= s;
        data_o   <= d;
        repeat (n - 1) @(posedge clock_i);
    endtask

    // master reset with loading method and timing mode presented on the pins
    task automatic mreset(input logic ld, input logic fw);
        @(posedge clock_i);
        master_reset_n_o <= 1'b0;
        ctl_o            <= {ld, 3'b111};
        serial_o         <= fw;
        repeat (5) @(posedge clock_i);
        master_reset_n_o <= 1'b1;
        repeat (8) @(posedge clock_i);
        ctl_o            <= 4'hF;
        repeat (6) @(posedge clock_i);
    endtask

    // sends offset bits lo..hi-1, one per edge, then idles six edges with the last bit inverted on the serial line
    task automatic shift(input logic [25:0] b, input int lo, input int hi);
        for (int i = lo; i < hi; i++) begin
            drive(4'b0110, b[i], 18'h00000, 1);
        end
        drive(4'hF, ~b[hi-1], 18'h3FFFF, 6);
    endtask
endmodule
`default_nettype wire

// File: fof_flags_offset_tb_top.sv
// self-checking bench for the fifo flag and offset programming block
// assumes fof_pkg, fof_pin_agent and the design are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "fof_consts.svh"

module fof_flags_offset_tb_top;
    localparam logic [3:0] MWR = 4'b1011;
    localparam logic [3:0] MRD = 4'b1101;
    localparam logic [3:0] PWR = 4'b0011;
    localparam logic [3:0] PRD = 4'b0101;
    localparam logic [3:0] IDLE = 4'hF;
    logic                  clock_i;
    logic                  reset_n_i;
    logic                  mrs_n;
    logic [3:0]            ctl;
    logic                  si;
    logic [17:0]           din;
    logic [17:0]           dout;
    fof_pkg::fof_flags_t   flags;
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [3:0]            adr;
    logic [31:0]           wdat;
    logic [31:0]           rdat;
    logic                  ack;
    logic [31:0]           rd;
    int                    n_errors;
    int                    checks_done;
    int                    cycles = 0;

    fof_pin_agent agent (.clock_i(clock_i), .master_reset_n_o(mrs_n), .ctl_o(ctl),
        .serial_o(si), .data_o(din));
    fof_flags_offset uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .master_reset_n_i(mrs_n),
        .load_select_n_i(ctl[3]), .write_enable_n_i(ctl[2]), .read_enable_n_i(ctl[1]),
        .serial_enable_n_i(ctl[0]), .fallthrough_serial_pin_i(si), .data_in_bus_i(din),
        .data_out_bus_o(dout), .flags_o(flags), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clock_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // writes or reads n words, lets pins settle, then compares the flags
    task automatic fill(input logic [3:0] c, input int n, input logic [4:0] exp);
        agent.drive(c, 1'b0, 18'h155AA, n);
        agent.drive(IDLE, 1'b0, 18'h2AA55, 6);
        chk("flags", {27'h0, exp}, {27'h0, flags});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_defaults();
        chk("flags", 32'h1C, {27'h0, flags});
        wb(1'b0, 4'hC, 32'h0);
        chk("offsets", 32'h007F007F, rd);
        wb(1'b0, 4'h4, 32'h0);
        chk("status", 32'h001C, {19'h0, rd[15:8], rd[4:0]});
        wb(1'b0, 4'h6, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test defaults done");
    endtask

    task automatic test_parallel();
        agent.drive(PWR, 1'b0, 18'h00002, 1);
        agent.drive(PWR, 1'b0, 18'h00003, 1);
        agent.drive(IDLE, 1'b0, 18'h3FFFC, 6);
        wb(1'b0, 4'hC, 32'h0);
        chk("offsets", 32'h00030002, rd);
        agent.shift(26'h3FFFFFF, 0, 1);
        wb(1'b0, 4'h4, 32'h0);
        chk("serial index", 32'h0, {27'h0, rd[14:10]});
        for (int i = 0; i < 3; i++) begin
            agent.drive(PRD, 1'b0, 18'h0, 1);
            agent.drive(IDLE, 1'b0, 18'h0, 6);
            chk("readback", (i == 1) ? 32'h3 : 32'h2, {14'h0, dout});
        end
        $display("test parallel done");
    endtask

    task automatic test_std_flags();
        fill(MWR, 2, 5'b11101);
        fill(MWR, 1, 5'b11111);
        fill(MWR, 4093, 5'b11111);
        fill(MWR, 1, 5'b11011);
        fill(MWR, 4091, 5'b11011);
        fill(MWR, 1, 5'b10011);
        fill(MWR, 4, 5'b00011);
        wb(1'b0, 4'h8, 32'h0);
        chk("count", 32'h2000, {18'h0, rd[13:0]});
        fill(MRD, 1, 5'b10011);
        chk("read data", 32'h155AA, {14'h0, dout});
        $display("test standard flags done");
    endtask

    task automatic test_serial();
        agent.mreset(1'b1, 1'b1);
        chk("flags", 32'h0D, {27'h0, flags});
        wb(1'b0, 4'h4, 32'h0);
        chk("mode", 32'h3, {30'h0, rd[9:8]});
        agent.drive(PWR, 1'b0, 18'h00007, 1);
        agent.drive(IDLE, 1'b0, 18'h0, 6);
        wb(1'b0, 4'hC, 32'h0);
        chk("offsets", 32'h03FF03FF, rd);
        agent.shift({13'd9, 13'd5}, 0, 10);
        agent.drive(4'b0111, 1'b1, 18'h0, 4);
        agent.drive(MWR, 1'b1, 18'h00011, 2);
        agent.drive(IDLE, 1'b0, 18'h0, 6);
        wb(1'b0, 4'h4, 32'h0);
        chk("pause state", 32'h2A, {26'h0, rd[15:10]});
        chk("fall-through word", 32'h11, {14'h0, dout});
        agent.shift({13'd9, 13'd5}, 10, 26);
        wb(1'b0, 4'hC, 32'h0);
        chk("offsets", 32'h00090005, rd);
        wb(1'b0, 4'h8, 32'h0);
        chk("count", 32'h2, {18'h0, rd[13:0]});
        $display("test serial done");
    endtask

    task automatic test_first_word_fallthrough_flags();
        fill(MWR, 4, 5'b01100);
        fill(MWR, 1, 5'b01110);
        fill(MWR, 4090, 5'b01110);
        fill(MWR, 1, 5'b01010);
        fill(MWR, 4085, 5'b01010);
        fill(MWR, 1, 5'b00010);
        fill(MWR, 9, 5'b10010);
        agent.drive(PRD, 1'b0, 18'h0, 1);
        agent.drive(IDLE, 1'b0, 18'h0, 6);
        chk("readback", 32'h5, {14'h0, dout});
        $display("test fall-through flags done");
    endtask

    // soft master reset over the bus recaptures the method from the idle pins
    task automatic test_soft_reset();
        wb(1'b1, 4'h0, 32'h1);
        wb(1'b0, 4'h0, 32'h0);
        chk("soft reset bit", 32'h1, rd);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk("count", 32'h0, rd);
        wb(1'b0, 4'hC, 32'h0);
        chk("offsets", 32'h03FF03FF, rd);
        wb(1'b0, 4'h4, 32'h0);
        chk("status", 32'h21C, {22'h0, rd[9:0]});
        $display("test soft reset done");
    endtask

    // ****************************************************************
    // clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
    end

    initial begin
        n_errors    = 0;
        checks_done = 0;
        reset_n_i   = 1'b0;
        {cyc, stb, we} = 3'b000;
        adr         = 4'h0;
        wdat        = 32'h0;
        repeat (4) @(posedge clock_i);
        reset_n_i <= 1'b1;
        fork
            begin
                agent.mreset(1'b0, 1'b0);
                test_defaults();
                test_parallel();
                test_std_flags();
                test_serial();
                test_first_word_fallthrough_flags();
                test_soft_reset();
            end
            begin
                wait (cycles == 60000);
                n_errors++;
                $display("MISMATCH run length expected below 60000 seen %0d", cycles);
            end
        join_any
        give_verdict();
    end
endmodule
`default_nettype wire
